// [verilog/selftest_pkg.sv]
// Purpose: Shared constants for the PHY self-test and loopback register block
// Assumes: 250 MHz core clock, 16-bit management registers
// Notes:   Both ends import this package
package selftest_pkg;

  localparam logic [4:0]  ADDR_RX_ERROR_TALLY    = 5'h15;
  localparam logic [4:0]  ADDR_SELFTEST_CONTROL  = 5'h16;
  localparam logic [4:0]  ADDR_TEST_STATUS_TWO   = 5'h17;
  localparam logic [15:0] TALLY_MAX              = 16'hffff;
  localparam logic [15:0] CONTROL_RESET          = 16'h0000;
  localparam logic [15:0] CONTROL_WRITE_MASK     = 16'hf0ff;
  localparam int          BIT_CONT_MODE          = 15;
  localparam int          BIT_RANDOM_PAYLOAD     = 14;
  localparam int          BIT_SHORT_FRAME        = 13;
  localparam int          BIT_GEN_ENABLE         = 12;
  localparam int          BIT_REV_RX_FORWARD     = 7;
  localparam int          BIT_MII_TX_FORWARD     = 6;
  localparam int          LOOP_POINT_LSB         = 2;
  localparam int          BIT_SYNC               = 11;
  localparam int          BIT_SYNC_LOST          = 10;
  localparam int          BIT_ACTIVE             = 9;
  localparam int          BIT_MASTER_LEGACY      = 8;
  localparam int          BIT_SLAVE_LEGACY       = 7;
  localparam int          BIT_CORE_AWAKE         = 6;
  localparam logic [3:0]  LOOP_REVERSE           = 4'h8;
  localparam logic [3:0]  LOOP_EXTERNAL          = 4'h4;
  localparam logic [3:0]  LOOP_ANALOG            = 4'h2;
  localparam logic [3:0]  LOOP_DIGITAL           = 4'h1;
  localparam logic [10:0] SHORT_FRAME_BYTES      = 11'd64;
  localparam logic [10:0] LONG_FRAME_BYTES       = 11'd1518;
  localparam logic [15:0] PRBS_COUNT_MAX         = 16'hffff;
  localparam logic [15:0] PRBS_SEED              = 16'hace1;
  localparam logic [4:0]  CMD_ADDR_STATUS        = 5'h00;

  typedef enum logic [2:0] {
    GEN_IDLE = 3'b001,
    GEN_SEND = 3'b010,
    GEN_DONE = 3'b100
  } gen_state_t;

  typedef enum logic [3:0] {
    COD_NONE      = 4'b0001,
    COD_PRE_SCRAM = 4'b0010,
    COD_POST_SCR  = 4'b0100,
    COD_POST_MLT3 = 4'b1000
  } coding_loop_t;

endpackage

// [verilog/mgmt_if.sv]
`timescale 1ns/100ps
// Purpose: Management register path between software-side controller and PHY test block
// Assumes: Single clock, read data one cycle after the read strobe
// Notes:   The controller drives address, data and strobes
interface mgmt_if;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;

  modport phy  (input addr, input wdata, input wr, input rd, output rdata);
  modport ctrl (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// [verilog/selftest_regs.sv]
`timescale 1ns/100ps
// Purpose: Self-test, loopback and receive-error tally registers of the PHY
// Assumes: Management access one cycle, inputs synchronous to clk
// Notes:   Packet generator is a byte-per-cycle model of the test stream
module selftest_regs
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  // Management
  mgmt_if.phy                               mgmt,
  // Datapath status
  input  wire logic                         rx_error,
  input  wire logic                         speed_gig,
  input  wire logic                         checker_sync_in,
  input  wire logic                         master_legacy_in,
  input  wire logic                         slave_legacy_in,
  input  wire logic                         core_awake_in,
  // Loopback steering
  output logic [3:0]                        loop_point,
  output selftest_pkg::coding_loop_t        coding_loop,
  output logic                              gig_coding_loop,
  output logic                              rx_to_mac_en,
  output logic                              tx_to_line_en,
  // Generator and checker
  output logic                              gen_byte_valid,
  output logic [7:0]                        gen_byte,
  output logic                              checker_enable,
  output logic                              prbs_wrap_pulse
);
  import selftest_pkg::*;

  // ************************************************************
  // Registers
  // ************************************************************
  logic [15:0] tally_q;
  logic [15:0] control_q;
  logic        rx_error_q;
  logic        sync_q;
  logic        sync_lost_q;
  logic [15:0] rdata_q;
  logic [15:0] lfsr_q;
  logic [15:0] prbs_count_q;
  logic [10:0] byte_count_q;
  logic        wrap_q;
  gen_state_t  gen_q;

  wire logic cont_mode   = control_q[BIT_CONT_MODE];
  wire logic random_sel  = control_q[BIT_RANDOM_PAYLOAD];
  wire logic gen_en      = control_q[BIT_GEN_ENABLE];
  wire logic [10:0] frame_bytes = control_q[BIT_SHORT_FRAME] ? SHORT_FRAME_BYTES
                                                             : LONG_FRAME_BYTES;
  wire logic status_read = mgmt.rd && (mgmt.addr == ADDR_TEST_STATUS_TWO);

  // ************************************************************
  // Receive error tally
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      tally_q    <= 16'h0000;
      rx_error_q <= 1'b0;
    end
    else
    begin
      rx_error_q <= rx_error;
      if (mgmt.wr && mgmt.addr == ADDR_RX_ERROR_TALLY)
        tally_q <= 16'h0000;
      else if (rx_error && !rx_error_q && tally_q != TALLY_MAX)
        tally_q <= tally_q + 16'h0001;
    end

  // ************************************************************
  // Control register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      control_q <= CONTROL_RESET;
    else if (mgmt.wr && mgmt.addr == ADDR_SELFTEST_CONTROL)
      control_q <= mgmt.wdata & CONTROL_WRITE_MASK;
    else if (gen_q == GEN_DONE && !random_sel)
      control_q[BIT_GEN_ENABLE] <= 1'b0;

  // ************************************************************
  // Loopback steering
  // ************************************************************
  // Forward bits only take effect in their own loop mode; software must not set them elsewhere
  assign loop_point    = control_q[LOOP_POINT_LSB +: 4];
  assign rx_to_mac_en  = (loop_point != LOOP_REVERSE) || control_q[BIT_REV_RX_FORWARD];
  assign tx_to_line_en = (loop_point != LOOP_DIGITAL) || control_q[BIT_MII_TX_FORWARD];
  assign gig_coding_loop = speed_gig && control_q[0];

  always_comb
  begin
    coding_loop = COD_NONE;
    if (!speed_gig)
      case (control_q[1:0])
        2'b11:   coding_loop = COD_POST_MLT3;
        2'b10:   coding_loop = COD_POST_SCR;
        2'b01:   coding_loop = COD_PRE_SCRAM;
        default: coding_loop = COD_NONE;
      endcase
  end

  // ************************************************************
  // Packet and PRBS generator
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      gen_q        <= GEN_IDLE;
      byte_count_q <= 11'd0;
    end
    else
      case (gen_q)
        GEN_IDLE:
          if (gen_en)
          begin
            gen_q        <= GEN_SEND;
            byte_count_q <= 11'd0;
          end
        GEN_SEND:
          if (!gen_en)
            gen_q <= GEN_IDLE;
          else if (byte_count_q == frame_bytes - 11'd1)
          begin
            byte_count_q <= 11'd0;
            gen_q        <= random_sel ? GEN_SEND : GEN_DONE;
          end
          else
            byte_count_q <= byte_count_q + 11'd1;
        GEN_DONE:
          gen_q <= GEN_IDLE;
        default:
          gen_q <= GEN_IDLE;
      endcase

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      lfsr_q <= PRBS_SEED;
    else if (gen_q == GEN_SEND && random_sel)
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      gen_byte_valid <= 1'b0;
      gen_byte       <= 8'h00;
    end
    else
    begin
      gen_byte_valid <= (gen_q == GEN_SEND) && gen_en;
      gen_byte       <= random_sel ? lfsr_q[7:0] : 8'h55;
    end

  // Checker runs only with random payload; constant payload disables it
  assign checker_enable = random_sel;

  // ************************************************************
  // PRBS counter and wrap pulse
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      prbs_count_q <= 16'h0000;
      wrap_q       <= 1'b0;
    end
    else
    begin
      wrap_q <= 1'b0;
      if (random_sel && (gen_q == GEN_SEND || checker_sync_in))
      begin
        if (prbs_count_q == PRBS_COUNT_MAX && cont_mode)
        begin
          prbs_count_q <= 16'h0000;
          wrap_q       <= 1'b1;
        end
        else if (prbs_count_q != PRBS_COUNT_MAX)
          prbs_count_q <= prbs_count_q + 16'h0001;
      end
    end
  assign prbs_wrap_pulse = wrap_q;

  // ************************************************************
  // Checker lock status
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      sync_q      <= 1'b0;
      sync_lost_q <= 1'b0;
    end
    else
    begin
      sync_q <= checker_sync_in && checker_enable;
      // A loss in the same cycle as the clearing read is kept
      if (sync_q && !(checker_sync_in && checker_enable))
        sync_lost_q <= 1'b1;
      else if (status_read)
        sync_lost_q <= 1'b0;
    end

  // ************************************************************
  // Read path
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      rdata_q <= 16'h0000;
    else if (mgmt.rd)
      case (mgmt.addr)
        ADDR_RX_ERROR_TALLY:   rdata_q <= tally_q;
        ADDR_SELFTEST_CONTROL: rdata_q <= control_q;
        ADDR_TEST_STATUS_TWO:
        begin
          rdata_q                    <= 16'h0000;
          rdata_q[BIT_SYNC]          <= sync_q;
          rdata_q[BIT_SYNC_LOST]     <= sync_lost_q;
          rdata_q[BIT_ACTIVE]        <= (gen_q != GEN_IDLE);
          rdata_q[BIT_MASTER_LEGACY] <= master_legacy_in;
          rdata_q[BIT_SLAVE_LEGACY]  <= slave_legacy_in;
          rdata_q[BIT_CORE_AWAKE]    <= core_awake_in;
        end
        default:               rdata_q <= 16'h0000;
      endcase
  assign mgmt.rdata = rdata_q;

endmodule // selftest_regs

// [verilog/selftest_ctrl.sv]
`timescale 1ns/100ps
// Purpose: Software-side controller that drives the PHY test registers
// Assumes: Software port: address, write data, strobes, read data next cycle
// Notes:   Passes address, strobes and read data straight through; reshapes control-register write data into safe settings
module selftest_ctrl
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Software port
  input  wire logic [4:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [15:0]      sw_rdata,
  // Management
  mgmt_if.ctrl             mgmt
);
  import selftest_pkg::*;

  // ************************************************************
  // Write shaping
  // ************************************************************
  logic [15:0] shadow_q;
  logic [15:0] wdata_c;

  // Shadow keeps what the register really took, so the loop point compare is exact
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      shadow_q <= CONTROL_RESET;
    else if (sw_wr && sw_addr == ADDR_SELFTEST_CONTROL)
      shadow_q <= wdata_c & CONTROL_WRITE_MASK;

  always_comb
  begin
    wdata_c = sw_wdata;
    if (sw_addr == ADDR_SELFTEST_CONTROL)
    begin
      wdata_c[BIT_CONT_MODE] = 1'b1;
      // More than one loop point at once is refused as no loop at all
      if (!$onehot0(wdata_c[5:2]))
        wdata_c[5:2] = 4'h0;
      // Coding loop must be zero when the loop point changes
      if (wdata_c[5:2] != shadow_q[5:2])
        wdata_c[1:0] = 2'b00;
      if (wdata_c[5:2] != LOOP_REVERSE)
        wdata_c[BIT_REV_RX_FORWARD] = 1'b0;
      if (wdata_c[5:2] != LOOP_DIGITAL)
        wdata_c[BIT_MII_TX_FORWARD] = 1'b0;
    end
  end

  assign mgmt.addr  = sw_addr;
  assign mgmt.wdata = wdata_c;
  assign mgmt.wr    = sw_wr;
  assign mgmt.rd    = sw_rd;
  assign sw_rdata   = mgmt.rdata;

endmodule // selftest_ctrl

// [test/selftest_asserts.sv]
// Purpose: Checks on the management path and steering outputs
// Assumes: One clock, read data in the cycle after rd
// Notes:   Tally saturation is too long to reach in simulation
`timescale 1ns/100ps
module selftest_asserts
  import selftest_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Management
  input wire logic [4:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  // Steering
  input wire logic        speed_gig,
  input wire logic        checker_sync_in,
  input wire logic        checker_enable,
  input wire logic [3:0]  loop_point,
  input wire logic        gig_coding_loop,
  input wire logic        rx_to_mac_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  property p_stat_rsv;
    rd && addr == ADDR_TEST_STATUS_TWO |=> rdata[15:12] == 4'h0 && rdata[5:0] == 6'h00;
  endproperty
  a_stat_rsv: assert property (p_stat_rsv) else $error("status reserved bits set");
  property p_ctl_rsv;
    rd && addr == ADDR_SELFTEST_CONTROL |=> rdata[11:8] == 4'h0 && rdata[15];
  endproperty
  a_ctl_rsv: assert property (p_ctl_rsv) else $error("control read back wrong");
  property p_cont;
    wr && addr == ADDR_SELFTEST_CONTROL |-> wdata[15];
  endproperty
  a_cont: assert property (p_cont) else $error("control write without mode bit");
  property p_sync;
    rd && addr == ADDR_TEST_STATUS_TWO
      |=> rdata[11] == ($past(checker_sync_in, 2) && $past(checker_enable, 2));
  endproperty
  a_sync: assert property (p_sync) else $error("sync flag wrong");
  property p_clear;
    wr && addr == ADDR_RX_ERROR_TALLY ##[1:2] rd && addr == ADDR_RX_ERROR_TALLY
      |=> rdata == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("tally not cleared");
  property p_unmap;
    rd && (addr < ADDR_RX_ERROR_TALLY || addr > ADDR_TEST_STATUS_TWO) |=> rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_onehot;
    $onehot0(loop_point);
  endproperty
  a_onehot: assert property (p_onehot) else $error("loop point not one-hot");
  property p_gig;
    gig_coding_loop |-> speed_gig;
  endproperty
  a_gig: assert property (p_gig) else $error("gigabit loop outside gigabit");
  property p_rxfwd;
    !rx_to_mac_en |-> loop_point == LOOP_REVERSE;
  endproperty
  a_rxfwd: assert property (p_rxfwd) else $error("receive blocked outside reverse");
  property p_rst;
    $rose(rst_b) |-> rdata == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("read data not zero after reset");
  c_ctl: cover property (wr && addr == ADDR_SELFTEST_CONTROL);
  c_stat: cover property (rd && addr == ADDR_TEST_STATUS_TWO);
  c_rev: cover property (loop_point == LOOP_REVERSE);
endmodule // selftest_asserts

// [test/tb.sv]
// Purpose: Bench for controller and test registers joined back to back
// Assumes: 250 MHz clock, reset held 20 cycles
// Notes:   Tally saturation and PRBS wrap need too many cycles here
`timescale 1ns/100ps
module tb;
  import selftest_pkg::*;
  logic clk, rst_b, sw_wr, sw_rd, rx_error, speed_gig, sync_in, ml_in, sl_in, awake_in;
  logic gig_loop, rx_en, tx_en, gv, ck_en, wrap;
  logic [4:0] sw_addr;
  logic [15:0] sw_wdata, sw_rdata, d;
  logic [3:0] loop_point;
  logic [7:0] gb;
  coding_loop_t coding_loop;
  int bad_count, checked, nbytes, nodd;
  mgmt_if i_mgmt_if ();
  selftest_ctrl i_selftest_ctrl (.clk(clk), .rst_b(rst_b), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .mgmt(i_mgmt_if));
  selftest_regs i_selftest_regs (.clk(clk), .rst_b(rst_b), .mgmt(i_mgmt_if),
    .rx_error(rx_error), .speed_gig(speed_gig), .checker_sync_in(sync_in),
    .master_legacy_in(ml_in), .slave_legacy_in(sl_in), .core_awake_in(awake_in),
    .loop_point(loop_point), .coding_loop(coding_loop), .gig_coding_loop(gig_loop),
    .rx_to_mac_en(rx_en), .tx_to_line_en(tx_en), .gen_byte_valid(gv), .gen_byte(gb),
    .checker_enable(ck_en), .prbs_wrap_pulse(wrap));
  selftest_asserts i_selftest_asserts (.clk(clk), .rst_b(rst_b), .addr(i_mgmt_if.addr),
    .wdata(i_mgmt_if.wdata), .wr(i_mgmt_if.wr), .rd(i_mgmt_if.rd), .rdata(i_mgmt_if.rdata),
    .speed_gig(speed_gig), .checker_sync_in(sync_in), .checker_enable(ck_en),
    .loop_point(loop_point),
    .gig_coding_loop(gig_loop), .rx_to_mac_en(rx_en));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Counts every generated byte; odd ones differ from the constant fill
  always @(posedge clk)
    if (gv === 1'b1)
    begin
      nbytes++;
      if (gb !== 8'h55) nodd++;
    end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [4:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task wc(input logic [15:0] v, input logic [15:0] e);
    wr(ADDR_SELFTEST_CONTROL, v);
    rd(ADDR_SELFTEST_CONTROL);
    chk("control", e, d);
  endtask
  task give_verdict;
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // A hang anywhere ends the run as a failure
  initial
  begin
    #40000 bad_count++;
    give_verdict;
  end
  initial
  begin
    {sw_wr, sw_rd, rx_error, speed_gig, sync_in, ml_in, sl_in, awake_in} = 8'h00;
    {sw_addr, sw_wdata, rst_b} = 22'h000000;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_RX_ERROR_TALLY); chk("tally", 16'h0000, d);
    rd(ADDR_TEST_STATUS_TWO); chk("status", 16'h0000, d);
    repeat (5)
    begin
      @(posedge clk);
      rx_error <= 1'b1;
      @(posedge clk);
      rx_error <= 1'b0;
    end
    rd(ADDR_RX_ERROR_TALLY); chk("tally", 16'h0005, d);
    wr(ADDR_RX_ERROR_TALLY, 16'habcd);
    rd(ADDR_RX_ERROR_TALLY); chk("tally", 16'h0000, d);
    wr(5'h1f, 16'hffff);
    rd(5'h03); chk("unmapped", 16'h0000, d);
    wc(16'h0f23, 16'h8020);
    chk("loop", 16'(LOOP_REVERSE), 16'(loop_point)); chk("rxen", 16'h0000, 16'(rx_en));
    wc(16'h00a0, 16'h80a0); chk("rxen", 16'h0001, 16'(rx_en));
    wc(16'h0084, 16'h8004); chk("txen", 16'h0000, 16'(tx_en));
    wc(16'h0045, 16'h8045); chk("txen", 16'h0001, 16'(tx_en));
    chk("coding", 16'(COD_PRE_SCRAM), 16'(coding_loop));
    wc(16'h0046, 16'h8046); chk("coding", 16'(COD_POST_SCR), 16'(coding_loop));
    wc(16'h0047, 16'h8047); chk("coding", 16'(COD_POST_MLT3), 16'(coding_loop));
    wc(16'h0010, 16'h8010); chk("loop", 16'(LOOP_EXTERNAL), 16'(loop_point));
    wc(16'h0008, 16'h8008); chk("loop", 16'(LOOP_ANALOG), 16'(loop_point));
    speed_gig <= 1'b1;
    wc(16'h0009, 16'h8009); chk("gigloop", 16'h0001, 16'(gig_loop));
    // Random payload on, generator off: the checker stays enabled and can report lock
    wc(16'h400a, 16'hc00a); chk("gigloop", 16'h0000, 16'(gig_loop));
    @(posedge clk);
    {sync_in, ml_in, awake_in} <= 3'b111;
    rd(ADDR_TEST_STATUS_TWO); chk("status", 16'h0940, d);
    {sync_in, ml_in, sl_in, awake_in} <= 4'b0010;
    rd(ADDR_TEST_STATUS_TWO); chk("status", 16'h0480, d);
    rd(ADDR_TEST_STATUS_TWO); chk("status", 16'h0080, d);
    nbytes = 0;
    wr(ADDR_SELFTEST_CONTROL, 16'h3000);
    rd(ADDR_TEST_STATUS_TWO); chk("busy", 16'h0200, d & 16'h0200);
    repeat (300) @(posedge clk);
    #1 chk("bytes", 16'd64, 16'(nbytes)); chk("fill", 16'h0000, 16'(nodd));
    rd(ADDR_SELFTEST_CONTROL); chk("control", 16'ha000, d);
    chk("ckon", 16'h0000, 16'(ck_en));
    nbytes = 0;
    wr(ADDR_SELFTEST_CONTROL, 16'h1000);
    repeat (1700) @(posedge clk);
    #1 chk("bytes", 16'd1518, 16'(nbytes));
    rd(ADDR_TEST_STATUS_TWO); chk("busy", 16'h0000, d & 16'h0200);
    nbytes = 0;
    wr(ADDR_SELFTEST_CONTROL, 16'h7000); chk("ckon", 16'h0001, 16'(ck_en));
    repeat (300) @(posedge clk);
    #1 chk("b2b", 16'h0001, 16'(nbytes > 64));
    wr(ADDR_SELFTEST_CONTROL, 16'h6000);
    repeat (100) @(posedge clk);
    rd(ADDR_TEST_STATUS_TWO); chk("busy", 16'h0000, d & 16'h0200);
    chk("ckon", 16'h0001, 16'(ck_en));
    wc(16'h603c, 16'he000); chk("loop", 16'h0000, 16'(loop_point));
    give_verdict;
  end
endmodule // tb
